// >>> include/bst_params.svh
// Constants of the boundary-scan test access port: instruction codes, capture pattern, widths.
// Assumes the includer imports bst_pkg for the types that use these values.
// Function
// R1: Five TMS-high TCK rises reach Test-Logic-Reset.
// R2: Tester resets TAP after power-up.
// R3: Tester resets TAP before queue operation.
// R4: States advance on TCK rise by TMS.
// R5: Test-Logic-Reset disables all test logic.
// R6: Run-Test-Idle acts only if instruction needs.
// R7: Select states choose data, instruction or reset.
// R8: Capture-IR loads pattern ending in 01.
// R9: Shift-IR shifts instruction between TDI, TDO.
// R10: Exit states choose pause, update or shift.
// R11: Pause-IR holds instruction shift contents.
// R12: Update-IR latches instruction on TCK fall.
// R13: Capture-DR loads the selected data register.
// R14: Data states mirror instruction states.
// R15: Four-bit instruction, LSB nearest serial output.
// R16: Decode extest, sample, idcode, high-z, bypass.
// R17: Data registers share serial in and out.
// R18: Unselected data registers stay undisturbed.
// R19: Bypass clears to zero in Capture-DR.
// R20: Bypass leaves functional operation untouched.
// R21: Identification word: version, part, maker, one.
// R22: High-z floats outputs, selects bypass.
// R23: Extest drives and captures pins via chain.
// R24: Identification ready right after TAP reset.
// R25: Unknown codes bypass; TRST resets asynchronously.
`ifndef BST_PARAMS_SVH
`define BST_PARAMS_SVH
`define BST_IR_W       4
`define BST_ID_W       32
`define BST_IR_EXTEST  4'h0
`define BST_IR_SAMPLE  4'h1
`define BST_IR_IDCODE  4'h2
`define BST_IR_HIZ     4'h4
`define BST_IR_BYPASS  4'hF
`define BST_IR_CAPTURE 4'h1
`define BST_RESET_ONES 3'h5
`endif

// >>> include/bst_pkg.sv
// Types of the boundary-scan test access port.
// Assumes nothing of its surroundings.
package bst_pkg;
	typedef enum logic [3:0] {
		BST_TLR, BST_RTI, BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR, BST_PA_DR,
		BST_EX2_DR, BST_UPD_DR, BST_SEL_IR, BST_CAP_IR, BST_SH_IR, BST_EX1_IR,
		BST_PA_IR, BST_EX2_IR, BST_UPD_IR
	} bst_state_t;
	typedef enum logic [1:0] {BST_DR_BYP, BST_DR_ID, BST_DR_BSR} bst_dr_sel_t;
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} bst_link_t;
endpackage

// >>> rtl/bst_tap.sv
// Boundary-scan test access port: TAP controller, instruction register, bypass,
// identification and boundary chain, all sampled on the system clock.
// Assumes the tester clock is much slower than clock and the pins are glitch free.
`timescale 1ns/100ps
`include "bst_params.svh"
module bst_tap
	import bst_pkg::*;
#(
	parameter int          BSR_LEN    = 8,
	parameter logic [3:0]  ID_VERSION = 4'h1,  // Arbitrary value.
	parameter logic [15:0] ID_PART    = 16'h5A5A, // Arbitrary value.
	parameter logic [10:0] ID_MAKER   = 11'h2AA   // Arbitrary value.
)
(
	input  wire logic               clock,
	input  wire logic               resetn,
	input  wire logic               tck,
	input  wire logic               tms,
	input  wire logic               tdi,
	input  wire logic               trst_n,
	output logic                    tdo,
	output logic                    tdo_oe,
	input  wire logic [BSR_LEN-1:0] core_out,
	input  wire logic [BSR_LEN-1:0] core_oe,
	input  wire logic [BSR_LEN-1:0] pin_in,
	output logic      [BSR_LEN-1:0] pin_out,
	output logic      [BSR_LEN-1:0] pin_oe,
	output logic                    test_reset
);
	localparam logic [`BST_ID_W-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

	function automatic bst_state_t tap_next(input bst_state_t s, input logic m);
		bst_state_t n;
		n = BST_TLR;
		case (s)
			BST_TLR:    n = m ? BST_TLR : BST_RTI;
			BST_RTI:    n = m ? BST_SEL_DR : BST_RTI;
			BST_SEL_DR: n = m ? BST_SEL_IR : BST_CAP_DR;
			BST_CAP_DR: n = m ? BST_EX1_DR : BST_SH_DR;
			BST_SH_DR:  n = m ? BST_EX1_DR : BST_SH_DR;
			BST_EX1_DR: n = m ? BST_UPD_DR : BST_PA_DR;
			BST_PA_DR:  n = m ? BST_EX2_DR : BST_PA_DR;
			BST_EX2_DR: n = m ? BST_UPD_DR : BST_SH_DR;
			BST_UPD_DR: n = m ? BST_SEL_DR : BST_RTI;
			BST_SEL_IR: n = m ? BST_TLR : BST_CAP_IR;
			BST_CAP_IR: n = m ? BST_EX1_IR : BST_SH_IR;
			BST_SH_IR:  n = m ? BST_EX1_IR : BST_SH_IR;
			BST_EX1_IR: n = m ? BST_UPD_IR : BST_PA_IR;
			BST_PA_IR:  n = m ? BST_EX2_IR : BST_PA_IR;
			BST_EX2_IR: n = m ? BST_UPD_IR : BST_SH_IR;
			BST_UPD_IR: n = m ? BST_SEL_DR : BST_RTI;
			default:    n = BST_TLR;
		endcase
		return n;
	endfunction

	function automatic bst_dr_sel_t dr_decode(input logic [`BST_IR_W-1:0] code);
		bst_dr_sel_t d;
		case (code)
			`BST_IR_EXTEST, `BST_IR_SAMPLE: d = BST_DR_BSR;
			`BST_IR_IDCODE:                 d = BST_DR_ID;
			default:                        d = BST_DR_BYP;
		endcase
		return d;
	endfunction

	// Tester reset folds into the async reset; release is still synchronous to clock.
	logic [1:0] rst_sync_q;
	logic       rst_n;
	always_ff @(posedge clock or negedge resetn or negedge trst_n) // R25
	begin
		if (!resetn || !trst_n)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	bst_link_t            link_m_q;
	bst_link_t            link_s_q;
	logic                 tck_prev_q;
	logic [BSR_LEN-1:0]   pin_m_q;
	logic [BSR_LEN-1:0]   pin_s_q;
	logic                 rise;
	logic                 fall;
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// The scan clock may rest high when a reset ends. Starting the chain high means
			// that release can only show a false fall, which is harmless in Test-Logic-Reset.
			// A false rise would move the state machine.
			link_m_q   <= '{tck: 1'b1, tms: 1'b1, tdi: 1'b0};
			link_s_q   <= '{tck: 1'b1, tms: 1'b1, tdi: 1'b0};
			tck_prev_q <= 1'b1;
			pin_m_q    <= '0;
			pin_s_q    <= '0;
		end
		else
		begin
			link_m_q   <= '{tck: tck, tms: tms, tdi: tdi};
			link_s_q   <= link_m_q;
			tck_prev_q <= link_s_q.tck;
			pin_m_q    <= pin_in;
			pin_s_q    <= pin_m_q;
		end
	end
	assign rise = link_s_q.tck & ~tck_prev_q; // R4
	assign fall = ~link_s_q.tck & tck_prev_q;

	bst_state_t           st_q, st_d;
	logic [`BST_IR_W-1:0] irs_q, irs_d;
	logic [`BST_IR_W-1:0] ir_q, ir_d;
	logic                 byp_q, byp_d;
	logic [`BST_ID_W-1:0] id_q, id_d;
	logic [BSR_LEN-1:0]   bsh_q, bsh_d;
	logic [BSR_LEN-1:0]   bup_q, bup_d;
	logic                 tdo_q, tdo_d;
	logic                 tdo_oe_q, tdo_oe_d;
	logic [2:0]           ones_q, ones_d;
	logic [BSR_LEN-1:0]   pout_q, pout_d;
	logic [BSR_LEN-1:0]   poe_q, poe_d;
	bst_dr_sel_t          sel;
	logic                 extest;
	logic                 hiz;

	assign sel    = dr_decode(ir_q); // R16 R25
	assign extest = (ir_q == `BST_IR_EXTEST) && (st_q != BST_TLR);
	assign hiz    = (ir_q == `BST_IR_HIZ) && (st_q != BST_TLR);

	always_comb
	begin
		st_d     = st_q;
		irs_d    = irs_q;
		ir_d     = ir_q;
		byp_d    = byp_q;
		id_d     = id_q;
		bsh_d    = bsh_q;
		bup_d    = bup_q;
		tdo_d    = tdo_q;
		tdo_oe_d = tdo_oe_q;
		ones_d   = ones_q;
		if (rise)
		begin
			st_d = tap_next(st_q, link_s_q.tms); // R1 R4 R7 R10 R14
			if (!link_s_q.tms)
				ones_d = 3'h0;
			else if (ones_q != `BST_RESET_ONES)
				ones_d = ones_q + 3'h1;
			// Only the register in the path moves; the others keep their contents.
			case (st_q)
				BST_CAP_IR: irs_d = `BST_IR_CAPTURE; // R8
				BST_SH_IR:  irs_d = {link_s_q.tdi, irs_q[`BST_IR_W-1:1]}; // R9 R15
				BST_CAP_DR: // R13 R18
				begin
					case (sel)
						BST_DR_BYP: byp_d = 1'b0; // R19
						BST_DR_ID:  id_d = ID_WORD; // R21
						default:    bsh_d = pin_s_q; // R23
					endcase
				end
				BST_SH_DR: // R14 R17
				begin
					case (sel)
						BST_DR_BYP: byp_d = link_s_q.tdi;
						BST_DR_ID:  id_d = {link_s_q.tdi, id_q[`BST_ID_W-1:1]};
						default:    bsh_d = {link_s_q.tdi, bsh_q[BSR_LEN-1:1]};
					endcase
				end
				// Pause states and Run-Test-Idle hold everything; no instruction
				// here has work to do while idling.
				default: ; // R6 R11
			endcase
		end
		if (fall)
		begin
			tdo_oe_d = (st_q == BST_SH_IR) || (st_q == BST_SH_DR);
			if (st_q == BST_SH_IR)
				tdo_d = irs_q[0];
			else if (st_q == BST_SH_DR) // R17
			begin
				case (sel)
					BST_DR_BYP: tdo_d = byp_q;
					BST_DR_ID:  tdo_d = id_q[0];
					default:    tdo_d = bsh_q[0];
				endcase
			end
			if (st_q == BST_UPD_IR)
				ir_d = irs_q; // R12
			if ((st_q == BST_UPD_DR) && (sel == BST_DR_BSR))
				bup_d = bsh_q;
		end
		// Identification is current after any TAP reset, so a data scan reads it at once.
		if (st_q == BST_TLR)
			ir_d = `BST_IR_IDCODE; // R5 R24
		// Bypass and identification never touch the pins; functional values pass.
		if (hiz)
		begin
			pout_d = core_out;
			poe_d  = '0; // R22
		end
		else if (extest)
		begin
			pout_d = bup_q; // R23
			poe_d  = '1;
		end
		else
		begin
			pout_d = core_out; // R20
			poe_d  = core_oe;
		end
	end

	// Power-up lands in Test-Logic-Reset so the queue logic is never held by test mode.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q     <= BST_TLR; // R25
			irs_q    <= '0;
			ir_q     <= `BST_IR_IDCODE;
			byp_q    <= 1'b0;
			id_q     <= '0;
			bsh_q    <= '0;
			bup_q    <= '0;
			tdo_q    <= 1'b0;
			tdo_oe_q <= 1'b0;
			ones_q   <= 3'h0;
			pout_q   <= '0;
			poe_q    <= '0;
		end
		else
		begin
			st_q     <= st_d;
			irs_q    <= irs_d;
			ir_q     <= ir_d;
			byp_q    <= byp_d;
			id_q     <= id_d;
			bsh_q    <= bsh_d;
			bup_q    <= bup_d;
			tdo_q    <= tdo_d;
			tdo_oe_q <= tdo_oe_d;
			ones_q   <= ones_d;
			pout_q   <= pout_d;
			poe_q    <= poe_d;
		end
	end

	assign tdo        = tdo_q;
	assign tdo_oe     = tdo_oe_q;
	assign pin_out    = pout_q;
	assign pin_oe     = poe_q;
	assign test_reset = (st_q == BST_TLR);

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_rise_in(bst_state_t s);
		rise && (st_q == s);
	endsequence

	property p_five_ones;
		(ones_q == `BST_RESET_ONES) |-> (st_q == BST_TLR);
	endproperty
	a_five_ones: assert property (p_five_ones) else $error("TMS high run left reset"); // R1

	property p_cap_ir;
		s_rise_in(BST_CAP_IR) |=> (irs_q[1:0] == 2'b01) && (st_q != BST_CAP_IR);
	endproperty
	a_cap_ir: assert property (p_cap_ir) else $error("Capture-IR pattern wrong"); // R8

	property p_shift_ir;
		s_rise_in(BST_SH_IR) |=> (irs_q[3] == $past(link_s_q.tdi))
			&& (irs_q[2:0] == $past(irs_q[3:1]));
	endproperty
	a_shift_ir: assert property (p_shift_ir) else $error("Shift-IR did not shift"); // R9

	property p_pause_ir;
		(st_q == BST_PA_IR) |=> $stable(irs_q);
	endproperty
	a_pause_ir: assert property (p_pause_ir) else $error("Pause-IR changed bits"); // R11

	property p_upd_ir;
		fall && (st_q == BST_UPD_IR) |=> (ir_q == $past(irs_q)) ##1 $stable(ir_q);
	endproperty
	a_upd_ir: assert property (p_upd_ir) else $error("Update-IR did not latch"); // R12

	property p_bypass_cap;
		s_rise_in(BST_CAP_DR) ##0 (sel == BST_DR_BYP) |=> (byp_q == 1'b0);
	endproperty
	a_bypass_cap: assert property (p_bypass_cap) else $error("Bypass not cleared"); // R19

	property p_id_cap;
		s_rise_in(BST_CAP_DR) ##0 (sel == BST_DR_ID) |=> (id_q == ID_WORD) && (id_q[0] == 1'b1);
	endproperty
	a_id_cap: assert property (p_id_cap) else $error("Identification not loaded"); // R21

	property p_hiz;
		hiz |=> (pin_oe == '0);
	endproperty
	a_hiz: assert property (p_hiz) else $error("Output driven under high-z"); // R22

	property p_tlr_id;
		(st_q == BST_TLR) |=> (ir_q == `BST_IR_IDCODE) && (pin_oe == $past(core_oe));
	endproperty
	a_tlr_id: assert property (p_tlr_id) else $error("Reset state not idle"); // R5

	property p_step;
		!rise && !$past(rise) |=> $stable(st_q);
	endproperty
	a_step: assert property (p_step) else $error("State moved without TCK rise"); // R4
endmodule

// >>> verification/bst_tester.sv
// Tester model: drives the scan clock, mode and data pins of the port.
// Assumes its tasks are entered at a rising clock edge; scan clock is eight clocks.
`timescale 1ns/100ps
module bst_tester (
	input  wire logic clock,
	input  wire logic tdo,
	input  wire logic tdo_oe,
	output logic      tck,
	output logic      tms,
	output logic      tdi
);
	// High when the serial output was enabled at every shift step of the last scan.
	logic shift_oe;
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// Output is read at the end of the high phase, long after it settled from the last fall.
	task automatic step(input logic m, input logic d, output logic o);
		tck <= 1'b0;
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge clock);
		tck <= 1'b1;
		repeat (4) @(posedge clock);
		o = tdo;
	endtask
	task automatic reset5();
		logic o;
		repeat (5) step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
	task automatic scan(input logic ir, input int n, input int hold, input logic [31:0] din,
		output logic [31:0] dout);
		logic o;
		dout = '0;
		shift_oe = 1'b1;
		step(1'b1, 1'b0, o);
		if (ir)
			step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++)
		begin
			step((i == n - 1) || (i == hold), din[i], o);
			dout[i] = o;
			shift_oe = shift_oe & tdo_oe;
			// A hold parks in the pause state for two rises, then resumes shifting.
			if ((i == hold) && (i != n - 1))
			begin
				step(1'b0, 1'b0, o);
				step(1'b0, 1'b0, o);
				step(1'b1, 1'b0, o);
				step(1'b0, 1'b0, o);
			end
		end
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
		repeat (2) @(posedge clock);
	endtask
	task automatic scan_ir(input logic [3:0] din, output logic [3:0] dout);
		logic [31:0] w;
		scan(1'b1, 4, -1, {28'h0, din}, w);
		dout = w[3:0];
	endtask
	task automatic scan_ir_hold(input logic [3:0] din, input int hold, output logic [3:0] dout);
		logic [31:0] w;
		scan(1'b1, 4, hold, {28'h0, din}, w);
		dout = w[3:0];
	endtask
	task automatic scan_dr(input logic [31:0] din, output logic [31:0] dout);
		scan(1'b0, 32, -1, din, dout);
	endtask
endmodule

// >>> verification/tb.sv
// Self-checking bench of the test access port with an eight-cell boundary chain.
// Assumes the tester model drives the scan pins; the core side is held by the bench.
`timescale 1ns/100ps
module tb;
	localparam logic [3:0]  ID_V = 4'h1;      // Arbitrary value.
	localparam logic [15:0] ID_P = 16'h5A5A;  // Arbitrary value.
	localparam logic [10:0] ID_M = 11'h2AA;   // Arbitrary value.
	localparam logic [31:0] ID_WORD = {ID_V, ID_P, ID_M, 1'b1};
	logic        clock;
	logic        resetn;
	logic        trst_n;
	logic        tck;
	logic        tms;
	logic        tdi;
	logic        tdo;
	logic        tdo_oe;
	logic [7:0]  core_out;
	logic [7:0]  core_oe;
	logic [7:0]  pin_in;
	logic [7:0]  pin_out;
	logic [7:0]  pin_oe;
	logic        test_reset;
	logic [31:0] got;
	logic [3:0]  cap;
	int          failures = 0;
	int          check_count = 0;
	int          cycles = 0;
	bst_tap #(.BSR_LEN(8), .ID_VERSION(ID_V), .ID_PART(ID_P), .ID_MAKER(ID_M)) dut (
		.clock(clock), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi),
		.trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .test_reset(test_reset));
	bst_tester tst (.clock(clock), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
		.tdi(tdi));
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			failures++;
			stop_test();
		end
	end
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic t_id();
		tst.reset5();
		check(32'(test_reset), 32'h0);
		tst.scan(1'b0, 32, 5, 32'h0, got);
		check(got, ID_WORD);
		check(32'(tst.shift_oe), 32'h1);
		check(32'(tdo_oe), 32'h0);
		check(32'(pin_oe), 32'(core_oe));
	endtask
	// The second code is undecoded; the third floats the pins yet still bypasses.
	task automatic t_bypass();
		logic [3:0]  codes [3] = '{4'hF, 4'h7, 4'h4};
		logic [31:0] d = 32'hC0FFEE11;
		foreach (codes[i])
		begin
			tst.scan_ir(codes[i], cap);
			check(32'(cap), 32'h1);
			tst.scan_dr(d, got);
			check(got, d << 1);
			check(32'(pin_oe), codes[i] == 4'h4 ? 32'h0 : 32'(core_oe));
			check(32'(pin_out), 32'(core_out));
		end
	endtask
	// A 32-bit scan leaves the last eight bits shifted in as the preloaded chain.
	task automatic t_bsr();
		pin_in <= 8'h5C;
		tst.scan_ir(4'h1, cap);
		tst.scan_dr(32'hA500_0000, got);
		check(got, 32'h0000_005C);
		check(32'(pin_oe), 32'(core_oe));
		pin_in <= 8'h3A;
		tst.scan_ir(4'h0, cap);
		check(32'(pin_oe), 32'hFF);
		check(32'(pin_out), 32'hA5);
		tst.scan_dr(32'h0000_0000, got);
		check(got, 32'h0000_003A);
		check(32'(pin_out), 32'h00);
	endtask
	task automatic t_reset();
		logic o;
		tst.step(1'b1, 1'b0, o);
		tst.step(1'b0, 1'b0, o);
		tst.step(1'b0, 1'b0, o);
		repeat (4) tst.step(1'b1, 1'b0, o);
		repeat (2) @(posedge clock);
		check(32'(test_reset), 32'h0);
		tst.step(1'b1, 1'b0, o);
		repeat (2) @(posedge clock);
		check(32'(test_reset), 32'h1);
		tst.step(1'b0, 1'b0, o);
		tst.scan_ir_hold(4'hF, 1, cap);
		check(32'(cap), 32'h1);
		trst_n <= 1'b0;
		@(posedge clock);
		check(32'(test_reset), 32'h1);
		trst_n <= 1'b1;
		repeat (6) @(posedge clock);
		check(32'(test_reset), 32'h1);
		tst.step(1'b0, 1'b0, o);
		tst.scan_dr(32'h0, got);
		check(got, ID_WORD);
	endtask
	initial
	begin
		resetn = 1'b0;
		trst_n = 1'b0;
		core_out = 8'h96;
		core_oe = 8'h3C;
		pin_in = 8'h00;
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		trst_n <= 1'b1;
		repeat (6) @(posedge clock);
		check(32'(test_reset), 32'h1);
		t_id();
		t_bypass();
		t_bsr();
		t_reset();
		stop_test();
	end
endmodule
